// *** src/uabd_pkg.sv ***
// Package: register map, field positions, modes and state types of the autobaud block
package uabd_pkg;
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_STATUS = 8'h04;
   localparam logic [7:0]  OFF_DIVLO  = 8'h08;
   localparam logic [7:0]  OFF_DIVHI  = 8'h0C;
   localparam logic [7:0]  OFF_RXDATA = 8'h10;

   localparam int CTL_AUTOBAUD_ENABLE = 0;
   localparam int CTL_WAKE  = 1;
   localparam int CTL_WIDE  = 2;
   localparam int CTL_HS    = 3;
   localparam int CTL_SYNC  = 4;

   localparam int ST_RXF  = 0;
   localparam int ST_OVF  = 1;
   localparam int ST_IDLE = 2;
   localparam int ST_FERR = 3;
   localparam int ST_OERR = 4;

   localparam logic [6:0]  PRE_SLOW  = 7'd64;
   localparam logic [6:0]  PRE_MID   = 7'd16;
   localparam logic [6:0]  PRE_FAST  = 7'd4;
   localparam logic [2:0]  ABD_LAST  = 3'd7;
   localparam logic [2:0]  EDGE_LAST = 3'd4;
   localparam logic [2:0]  BITS_LAST = 3'd7;
   localparam logic [15:0] DIV_MAX   = 16'hFFFF;
   localparam logic [15:0] DIV_RST   = 16'h0000;
   localparam logic [15:0] CNT_START = 16'h0001;

   typedef enum logic [1:0] {AB_OFF, AB_START, AB_FIRST, AB_COUNT} uabd_ab_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uabd_rx_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } uabd_aphase_t;

   typedef struct packed {
      logic         autobaud_enable;
      logic         wakeEn;
      logic         wideSel;
      logic         hsSel;
      logic         syncMode;
      logic         ovf;
      logic         rxFlag;
      logic         ferr;
      logic         oerr;
      logic [15:0]  divisor;
      logic [6:0]   presc;
      logic [2:0]   abdSub;
      logic [2:0]   edgeCnt;
      uabd_ab_t     abSt;
      uabd_rx_t     rxSt;
      logic [2:0]   rxBit;
      logic [15:0]  rxTime;
      logic [7:0]   rxShift;
      logic [7:0]   rxData;
      logic [2:0]   lineSync;
      logic         lineF;
      logic         linePrev;
      uabd_aphase_t ap;
      logic [31:0]  rdata;
   } uabd_state_t;
endpackage

// *** src/uabd_top.sv ***
// Autobaud measurement, wake-on-break and a plain receiver behind an AHB-Lite slave
//
// The register addresses and the AHB-Lite register port were decided locally.
module uabd_top (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        receiveLine
);
   logic [1:0]           rstSync;
   logic                 rstN;
   uabd_pkg::uabd_state_t s;
   uabd_pkg::uabd_state_t n;
   logic                 baseTick;
   logic                 abdTick;
   logic                 lineRise;
   logic                 lineFall;
   logic                 wrCyc;
   logic                 rdData;
   logic [6:0]           preLimit;

   // Base clock divider per mode; sync mode ignores both select bits and runs fast
   function automatic logic [6:0] base_div(input logic sy, input logic wd, input logic hs);
      if (sy || (wd && hs)) begin
         base_div = uabd_pkg::PRE_FAST;
      end else if (wd || hs) begin
         base_div = uabd_pkg::PRE_MID;
      end else begin
         base_div = uabd_pkg::PRE_SLOW;
      end
   endfunction

   function automatic logic ap_hit(input uabd_pkg::uabd_aphase_t a, input logic [7:0] off);
      ap_hit = a.valid && (a.addr == off);
   endfunction

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;

   assign preLimit = base_div(s.syncMode, s.wideSel, s.hsSel);
   assign baseTick = (s.presc == preLimit - 7'd1);
   assign abdTick  = baseTick && (s.abdSub == uabd_pkg::ABD_LAST);
   assign lineRise = s.lineF && !s.linePrev;
   assign lineFall = !s.lineF && s.linePrev;
   assign wrCyc    = s.ap.valid && s.ap.write;
   assign rdData   = hsel && htrans[1] && hready && !hwrite
                     && (haddr[7:0] == uabd_pkg::OFF_RXDATA);

   always_comb begin
      n = s;
      // Three-stage sync; only stages two and three are compared
      n.lineSync = {s.lineSync[1:0], receiveLine};
      if (s.lineSync[1] == s.lineSync[2]) begin
         n.lineF = s.lineSync[2];
      end
      n.linePrev = s.lineF;

      n.presc = baseTick ? 7'd0 : s.presc + 7'd1;
      if (baseTick) begin
         n.abdSub = s.abdSub + 3'd1;
      end

      // Address phase capture and read data, zero wait states
      n.ap.valid = hsel && htrans[1] && hready;
      n.ap.write = hwrite;
      n.ap.addr  = {haddr[7:2], 2'b00};
      if (hsel && htrans[1] && hready && !hwrite) begin
         unique case (haddr[7:0])
            uabd_pkg::OFF_CTRL:   n.rdata = {27'd0, s.syncMode, s.hsSel, s.wideSel,
                                             s.wakeEn, s.autobaud_enable};
            uabd_pkg::OFF_STATUS: n.rdata = {27'd0, s.oerr, s.ferr, s.rxSt == uabd_pkg::RX_IDLE,
                                             s.ovf, s.rxFlag};
            uabd_pkg::OFF_DIVLO:  n.rdata = {24'd0, s.divisor[7:0]};
            uabd_pkg::OFF_DIVHI:  n.rdata = {24'd0, s.divisor[15:8]};
            uabd_pkg::OFF_RXDATA: n.rdata = {24'd0, s.rxData};
            default:              n.rdata = 32'h0000_0000;
         endcase
      end

      // Software side first, so hardware sets below win in the same cycle
      if (rdData) begin
         n.rxFlag = 1'b0;
      end
      if (wrCyc && ap_hit(s.ap, uabd_pkg::OFF_CTRL)) begin
         n.autobaud_enable    = hwdata[uabd_pkg::CTL_AUTOBAUD_ENABLE];
         n.wakeEn   = hwdata[uabd_pkg::CTL_WAKE];
         n.wideSel  = hwdata[uabd_pkg::CTL_WIDE];
         n.hsSel    = hwdata[uabd_pkg::CTL_HS];
         n.syncMode = hwdata[uabd_pkg::CTL_SYNC];
         if (hwdata[uabd_pkg::CTL_AUTOBAUD_ENABLE] && !s.autobaud_enable) begin
            n.abSt = uabd_pkg::AB_START;
         end else if (!hwdata[uabd_pkg::CTL_AUTOBAUD_ENABLE]) begin
            n.abSt = uabd_pkg::AB_OFF;
         end
      end
      if (wrCyc && ap_hit(s.ap, uabd_pkg::OFF_STATUS)) begin
         // Write one to clear; the overflow clear is refused while measurement is armed
         if (hwdata[uabd_pkg::ST_OVF] && !s.autobaud_enable) begin
            n.ovf = 1'b0;
         end
         if (hwdata[uabd_pkg::ST_FERR]) begin
            n.ferr = 1'b0;
         end
         if (hwdata[uabd_pkg::ST_OERR]) begin
            n.oerr = 1'b0;
         end
      end
      // Divisor writes restart the timer; ignored while measuring
      if (wrCyc && !s.autobaud_enable && ap_hit(s.ap, uabd_pkg::OFF_DIVLO)) begin
         n.divisor[7:0] = hwdata[7:0];
         n.presc        = 7'd0;
      end
      if (wrCyc && !s.autobaud_enable && ap_hit(s.ap, uabd_pkg::OFF_DIVHI)) begin
         n.divisor[15:8] = hwdata[7:0];
         n.presc         = 7'd0;
      end

      // Wake-on-break; in sync mode the bit is a don't-care
      if (s.wakeEn && !s.syncMode) begin
         if (lineFall) begin
            n.rxFlag = 1'b1;
         end
         if (lineRise) begin
            n.wakeEn = 1'b0;
         end
      end

      // Autobaud measurement
      unique case (s.abSt)
         uabd_pkg::AB_OFF: begin
         end
         uabd_pkg::AB_START: begin
            // Break must be over before the sync start bit counts
            if (lineFall && !(s.wakeEn && !s.syncMode)) begin
               n.abSt = uabd_pkg::AB_FIRST;
            end
         end
         uabd_pkg::AB_FIRST: begin
            if (lineRise) begin
               n.divisor = uabd_pkg::CNT_START;
               n.edgeCnt = 3'd0;
               n.abdSub  = 3'd0;
               n.presc   = 7'd0;
               n.abSt    = uabd_pkg::AB_COUNT;
            end
         end
         uabd_pkg::AB_COUNT: begin
            if (abdTick) begin
               n.divisor = s.divisor + 16'd1;
               if (s.divisor == uabd_pkg::DIV_MAX) begin
                  n.ovf = 1'b1;
               end
            end
            if (lineRise) begin
               n.edgeCnt = s.edgeCnt + 3'd1;
               if (s.edgeCnt == uabd_pkg::EDGE_LAST - 3'd1) begin
                  n.autobaud_enable  = 1'b0;
                  n.rxFlag = 1'b1;
                  n.abSt   = uabd_pkg::AB_OFF;
                  if (!abdTick) begin
                     n.divisor = s.divisor;
                  end
               end
            end
         end
      endcase
      // An abort in the same cycle as an edge must not leave the machine running
      if (!n.autobaud_enable) begin
         n.abSt = uabd_pkg::AB_OFF;
      end

      // Plain 8N1 receiver: one bit is divisor+1 base ticks
      if (s.autobaud_enable || (s.wakeEn && !s.syncMode)) begin
         n.rxSt = uabd_pkg::RX_IDLE;
      end else begin
         if (baseTick) begin
            n.rxTime = s.rxTime + 16'd1;
         end
         unique case (s.rxSt)
            uabd_pkg::RX_IDLE: begin
               if (lineFall && !s.syncMode) begin
                  n.rxSt   = uabd_pkg::RX_START;
                  n.rxTime = 16'd0;
               end
            end
            uabd_pkg::RX_START: begin
               // Mid-bit check rejects glitches shorter than half a bit
               if (baseTick && s.rxTime >= (s.divisor >> 1)) begin
                  n.rxTime = 16'd0;
                  n.rxBit  = 3'd0;
                  n.rxSt   = s.lineF ? uabd_pkg::RX_IDLE : uabd_pkg::RX_DATA;
               end
            end
            uabd_pkg::RX_DATA: begin
               if (baseTick && s.rxTime >= s.divisor) begin
                  n.rxTime  = 16'd0;
                  n.rxShift = {s.lineF, s.rxShift[7:1]};
                  n.rxBit   = s.rxBit + 3'd1;
                  if (s.rxBit == uabd_pkg::BITS_LAST) begin
                     n.rxSt = uabd_pkg::RX_STOP;
                  end
               end
            end
            uabd_pkg::RX_STOP: begin
               if (baseTick && s.rxTime >= s.divisor) begin
                  n.rxData = s.rxShift;
                  n.ferr   = !s.lineF;
                  n.oerr   = s.oerr || (s.rxFlag && !rdData);
                  n.rxFlag = 1'b1;
                  n.rxSt   = uabd_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s          <= '0;
         s.lineSync <= 3'b111;
         s.lineF    <= 1'b1;
         s.linePrev <= 1'b1;
         s.divisor  <= uabd_pkg::DIV_RST;
         s.abSt     <= uabd_pkg::AB_OFF;
         s.rxSt     <= uabd_pkg::RX_IDLE;
      end else begin
         s <= n;
      end
   end

   chk_abd_done: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_COUNT && lineRise && s.edgeCnt == uabd_pkg::EDGE_LAST - 3'd1)
      |=> (!s.autobaud_enable && s.rxFlag && s.abSt == uabd_pkg::AB_OFF))
      else $error("autobaud completion missed");
   chk_abd_idle: assert property (@(posedge clk) disable iff (!rstN)
      s.autobaud_enable |=> s.rxSt == uabd_pkg::RX_IDLE)
      else $error("receiver ran during autobaud");
   chk_abd_first: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_FIRST && lineRise) |=> s.divisor == uabd_pkg::CNT_START)
      else $error("counter did not start at one");
   chk_ovf_set: assert property (@(posedge clk) disable iff (!rstN)
      $rose(s.ovf) |-> ($past(s.divisor) == uabd_pkg::DIV_MAX && $past(abdTick)))
      else $error("overflow flag without wrap");
   chk_ovf_hold: assert property (@(posedge clk) disable iff (!rstN)
      (s.ovf && s.autobaud_enable) |=> s.ovf)
      else $error("overflow cleared while enabled");
   chk_rd_clear: assert property (@(posedge clk) disable iff (!rstN)
      (rdData && !(s.wakeEn && lineFall) && s.abSt != uabd_pkg::AB_COUNT
       && s.rxSt != uabd_pkg::RX_STOP) |=> !s.rxFlag)
      else $error("receive read did not clear flag");
   chk_wake_flag: assert property (@(posedge clk) disable iff (!rstN)
      (s.wakeEn && !s.syncMode && lineFall) |=> s.rxFlag)
      else $error("wake event did not set flag");
   chk_wake_end: assert property (@(posedge clk) disable iff (!rstN)
      (s.wakeEn && !s.syncMode && lineRise && !wrCyc) |=> !s.wakeEn)
      else $error("wake enable not cleared at break end");
   chk_wake_idle: assert property (@(posedge clk) disable iff (!rstN)
      (s.wakeEn && !s.syncMode) |=> s.rxSt == uabd_pkg::RX_IDLE)
      else $error("receiver ran during wake wait");
   chk_sync_rate: assert property (@(posedge clk) disable iff (!rstN)
      s.syncMode |-> preLimit == uabd_pkg::PRE_FAST)
      else $error("sync mode base clock wrong");

   // Measurement sequencing; bus writes excluded where software may redirect it
   chk_abd_arm: assert property (@(posedge clk) disable iff (!rstN)
      $rose(s.autobaud_enable) |-> s.abSt == uabd_pkg::AB_START)
      else $error("autobaud enable did not arm");

   chk_start_wait: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_START && !lineFall && !wrCyc)
      |=> s.abSt == uabd_pkg::AB_START)
      else $error("autobaud left start wait early");

   chk_abd_skip: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_START && s.wakeEn && !s.syncMode)
      |=> s.abSt != uabd_pkg::AB_FIRST)
      else $error("autobaud started inside break");

   chk_first_wait: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_FIRST && !lineRise && !wrCyc)
      |=> s.abSt == uabd_pkg::AB_FIRST)
      else $error("count began before first rise");

   chk_sub_reset: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_FIRST && lineRise) |=> (s.abdSub == '0 && s.presc == '0))
      else $error("eighth divider not aligned at start");

   chk_edge_bound: assert property (@(posedge clk) disable iff (!rstN)
      s.abSt == uabd_pkg::AB_COUNT |-> s.edgeCnt < uabd_pkg::EDGE_LAST)
      else $error("edge count passed fifth edge");

   chk_abd_hold: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_COUNT && !abdTick) |=> $stable(s.divisor))
      else $error("divisor moved without a tick");

   chk_abd_step: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_COUNT && abdTick) |=> s.divisor == $past(s.divisor) + 16'h0001)
      else $error("divisor did not step by one");

   chk_ovf_keep: assert property (@(posedge clk) disable iff (!rstN)
      (s.abSt == uabd_pkg::AB_COUNT && s.ovf) |=> s.ovf)
      else $error("overflow lost while counting");

   chk_ovf_clear: assert property (@(posedge clk) disable iff (!rstN)
      (wrCyc && s.ap.addr == uabd_pkg::OFF_STATUS && hwdata[uabd_pkg::ST_OVF] && !s.autobaud_enable)
      |=> !s.ovf)
      else $error("overflow clear ignored after abort");

   chk_base_mid: assert property (@(posedge clk) disable iff (!rstN)
      (!s.syncMode && (s.wideSel != s.hsSel)) |-> preLimit == uabd_pkg::PRE_MID)
      else $error("single select base clock wrong");

   chk_base_slow: assert property (@(posedge clk) disable iff (!rstN)
      (!s.syncMode && !s.wideSel && !s.hsSel) |-> preLimit == uabd_pkg::PRE_SLOW)
      else $error("slow base clock wrong");

   chk_wake_sync: assert property (@(posedge clk) disable iff (!rstN)
      (s.syncMode && !s.rxFlag && s.abSt == uabd_pkg::AB_OFF && s.rxSt == uabd_pkg::RX_IDLE)
      |=> !s.rxFlag)
      else $error("flag raised in sync mode");

   chk_wake_keep: assert property (@(posedge clk) disable iff (!rstN)
      (s.wakeEn && !lineRise && !wrCyc) |=> s.wakeEn)
      else $error("wake enable dropped early");

   chk_line_filter: assert property (@(posedge clk) disable iff (!rstN)
      (s.lineSync[1] != s.lineSync[2]) |=> $stable(s.lineF))
      else $error("line changed before stages agreed");

   chk_rx_begin: assert property (@(posedge clk) disable iff (!rstN)
      (s.rxSt == uabd_pkg::RX_IDLE && lineFall && !s.syncMode && !s.autobaud_enable && !s.wakeEn)
      |=> s.rxSt == uabd_pkg::RX_START)
      else $error("start bit not taken");

   chk_stop_flag: assert property (@(posedge clk) disable iff (!rstN)
      (s.rxSt == uabd_pkg::RX_STOP && baseTick && s.rxTime >= s.divisor
       && !s.autobaud_enable && !s.wakeEn)
      |=> (s.rxFlag && s.rxSt == uabd_pkg::RX_IDLE))
      else $error("stop bit did not deliver byte");
endmodule // uabd_top

// *** test/testbench.sv ***
// Self-checking bench: register bus tasks, autobaud, receive and wake scenarios
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PER = 25;
   localparam int BIT = 160 * PER;

   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        rxLine;
   logic [31:0] rd;
   int          err_count = 0;
   int          total_checks = 0;

   always #(PER / 2.0) clk = ~clk;

   uabd_top dut_u (
      .clk         (clk),
      .nrst        (nrst),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hsize       (hsize),
      .hwdata      (hwdata),
      .hready      (hreadyout),
      .hreadyout   (hreadyout),
      .hrdata      (hrdata),
      .hresp       (hresp),
      .receiveLine (rxLine)
   );

   uabd_node node_u (
      .line (rxLine)
   );

   task automatic fail(input string m);
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   // Single word transfer; read data lands in rd
   task automatic bus_cyc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h00_0000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      if (hresp !== 1'b0) begin
         fail("error response");
      end
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      bus_cyc(1'b0, a, 32'h0000_0000);
      total_checks++;
      if ((rd & mask) !== exp) begin
         fail($sformatf("addr %h read %h want %h", a, rd & mask, exp));
      end
   endtask

   // Prescaler phase leaves one count of slack either way
   task automatic div_chk(input int exp);
      logic [15:0] d;
      bus_cyc(1'b0, uabd_pkg::OFF_DIVLO, 32'h0000_0000);
      d[7:0] = rd[7:0];
      bus_cyc(1'b0, uabd_pkg::OFF_DIVHI, 32'h0000_0000);
      d[15:8] = rd[7:0];
      total_checks++;
      if (d !== 16'(exp) && d !== 16'(exp - 1) && d !== 16'(exp + 1)) begin
         fail($sformatf("divisor %h want about %0d", d, exp));
      end
   endtask

   task automatic test_reset;
      chk(uabd_pkg::OFF_CTRL, 32'h0000_001F, 32'h0000_0000);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_001B, 32'h0000_0000);
      chk(uabd_pkg::OFF_DIVLO, 32'hFFFF_FFFF, 32'h0000_0000);
      chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic test_autobaud;
      int          abdDiv [4] = '{512, 128, 128, 32};
      logic [31:0] mode;
      int          bitNs;
      for (int m = 0; m < 4; m++) begin
         mode = {28'h000_0000, m[0], m[1], 2'b00};
         bitNs = abdDiv[m] * 5 * PER;
         bus_cyc(1'b1, uabd_pkg::OFF_CTRL, mode | 32'h0000_0001);
         fork
            node_u.send_char(8'h55, bitNs);
            begin
               #(bitNs * 5);
               chk(uabd_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
            end
         join
         chk(uabd_pkg::OFF_CTRL, 32'h0000_001F, mode);
         chk(uabd_pkg::OFF_STATUS, 32'h0000_0009, 32'h0000_0001);
         div_chk(1 + 8 * bitNs / (abdDiv[m] * PER));
         bus_cyc(1'b0, uabd_pkg::OFF_RXDATA, 32'h0000_0000);
         chk(uabd_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      end
      $display("test autobaud done");
   endtask

   // Both selects set: bit is (n+1) times four clocks
   task automatic test_receive;
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_000C);
      bus_cyc(1'b1, uabd_pkg::OFF_DIVLO, 32'h0000_0027);
      bus_cyc(1'b1, uabd_pkg::OFF_DIVHI, 32'h0000_0000);
      node_u.send_char(8'hA3, BIT);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_0009, 32'h0000_0001);
      chk(uabd_pkg::OFF_RXDATA, 32'h0000_00FF, 32'h0000_00A3);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      $display("test receive done");
   endtask

   task automatic test_wake;
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_000E);
      fork
         node_u.send_break(13, BIT);
         begin
            #(BIT * 4);
            chk(uabd_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
            chk(uabd_pkg::OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
         end
      join
      chk(uabd_pkg::OFF_CTRL, 32'h0000_0002, 32'h0000_0000);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_0009, 32'h0000_0001);
      bus_cyc(1'b0, uabd_pkg::OFF_RXDATA, 32'h0000_0000);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      $display("test wake done");
   endtask

   // Measurement must skip the break and time the sync byte
   task automatic test_wake_abd;
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_000F);
      node_u.send_break(13, BIT);
      chk(uabd_pkg::OFF_CTRL, 32'h0000_001F, 32'h0000_000D);
      bus_cyc(1'b0, uabd_pkg::OFF_RXDATA, 32'h0000_0000);
      node_u.send_char(8'h55, BIT);
      chk(uabd_pkg::OFF_CTRL, 32'h0000_001F, 32'h0000_000C);
      div_chk(1 + 8 * 160 / 32);
      bus_cyc(1'b0, uabd_pkg::OFF_RXDATA, 32'h0000_0000);
      $display("test wake autobaud done");
   endtask

   task automatic test_sync;
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_0012);
      node_u.send_break(13, BIT);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_0000);
      $display("test sync done");
   endtask

   // Software abort: enable cleared first, then the overflow flag
   task automatic test_abort;
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_000D);
      chk(uabd_pkg::OFF_CTRL, 32'h0000_001F, 32'h0000_000D);
      bus_cyc(1'b1, uabd_pkg::OFF_CTRL, 32'h0000_000C);
      bus_cyc(1'b1, uabd_pkg::OFF_STATUS, 32'h0000_0002);
      chk(uabd_pkg::OFF_STATUS, 32'h0000_0003, 32'h0000_0000);
      chk(uabd_pkg::OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
      $display("test abort done");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      test_reset;
      test_autobaud;
      test_receive;
      test_wake;
      test_wake_abd;
      test_sync;
      test_abort;
      end_sim;
   end

   // Tests need about 51k cycles; this leaves margin
   initial begin
      #(90000 * PER);
      fail("timeout");
      end_sim;
   end
endmodule // testbench

// *** test/uabd_node.sv ***
// Remote serial node model that drives the receive line
module uabd_node (
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle high between frames, as a pulled-up line rests
   initial line = 1'b1;

   // Start bit, eight data bits LSB first, one stop bit
   task automatic send_char(input logic [7:0] b, input int bitNs);
      line <= 1'b0;
      #(bitNs);
      for (int i = 0; i < 8; i++) begin
         line <= b[i];
         #(bitNs);
      end
      line <= 1'b1;
      #(bitNs);
   endtask

   // Low break of nBits bit times, then idle long enough to settle
   task automatic send_break(input int nBits, input int bitNs);
      line <= 1'b0;
      #(nBits * bitNs);
      line <= 1'b1;
      #(2 * bitNs);
   endtask
endmodule // uabd_node
